//--- core/adc_mux_pkg.sv
// Purpose: Shared constants and types for the converter buffer and input-routing control block.
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word per register.
// Notes: Register fields sit in the low 16 bits of each word; upper bits read as zero.
package adc_mux_pkg;
  localparam int ADDR_W = 8;
  // Byte offsets of the registers.
  localparam logic [ADDR_W-1:0] OFF_BUF_DMA_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CH123_SEL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CH0_SEL = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_MODE_CTRL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
  // Buffer/DMA configuration fields.
  localparam int POS_DMA_EN = 8;
  localparam int POS_DMA_BL = 0;
  // Channel 1-3 select fields.
  localparam int POS_CH123_NEG_B = 9;
  localparam int POS_CH123_POS_B = 8;
  localparam int POS_CH123_NEG_A = 1;
  localparam int POS_CH123_POS_A = 0;
  // Channel 0 select fields.
  localparam int POS_CH0_NEG_B = 15;
  localparam int POS_CH0_POS_B = 8;
  localparam int POS_CH0_NEG_A = 7;
  localparam int POS_CH0_POS_A = 0;
  // Mode control fields.
  localparam int POS_TWELVE_BIT = 0;
  localparam int POS_ALT_SETS = 1;
  localparam int POS_CHAN_COUNT = 2;
  localparam int POS_OPAMP_MODE = 4;
  // Status fields.
  localparam int POS_ST_SET_B = 0;
  localparam int POS_ST_BUF_PTR = 4;
  localparam int POS_ST_CH_EN = 8;
  // Reset values.
  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam logic [3:0] RST_BUF_PTR = 4'h0;
  // Channel 0 positive-select codes.
  localparam logic [4:0] CH0_OPAMP1 = 5'h18;
  localparam logic [4:0] CH0_OPAMP3 = 5'h1a;
  localparam logic [4:0] CH0_TEMP = 5'h1e;
  localparam logic [4:0] CH0_OPEN = 5'h1f;
  // Pin numbers used by the routing tables.
  localparam logic [3:0] PIN_LOW_NEG = 4'h9;
  localparam logic [3:0] PIN_HIGH_NEG_CH2 = 4'h7;
  localparam logic [3:0] PIN_CH0_NEG = 4'h1;
  // Pin shared with op amp 1, 2 and 3.
  localparam logic [3:0] PIN_SHARED_OA1 = 4'h3;
  localparam logic [3:0] PIN_SHARED_OA2 = 4'h0;
  localparam logic [3:0] PIN_SHARED_OA3 = 4'h6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {SRC_NONE, SRC_PIN, SRC_OPAMP, SRC_LOW_REF, SRC_TEMP, SRC_OPEN} src_kind_e;
  typedef struct packed {
    src_kind_e kind;
    logic [3:0] index;
  } src_s;
  typedef struct packed {
    logic valid;
    logic [11:0] data;
  } result_s;
endpackage

//--- core/adc_input_mux_dma_config.sv
// Purpose: Register block steering converter results and routing analog inputs to channels 0-3.
// Assumes: Single clock aclk at 20 MHz, synchronous active-low reset, AXI4-Lite master.
// Notes: Routing outputs follow register or set changes one clock later.
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none

// Function
// [R1] DMA enabled: every result lands in the first result register only.
// [R2] DMA disabled: results fill sixteen buffer registers, no DMA requests.
// [R3] Words per input equal two to the power of the three-bit field.
// [R4] Set B channels 1-3 negative: 11 pins 9-11, 10 op-amp3/7/8, 0x low reference.
// [R5] Set A channels 1-3 negative uses the same encoding at bits 2-1.
// [R6] Set B channels 1-3 positive bit: set op amps 1-3, clear op-amp2/pin1/pin2.
// [R7] Set A channels 1-3 positive bit at bit 0 routes like set B.
// [R8] In 12-bit mode all channel 1-3 select fields are absent and read zero.
// [R9] Set B channel 0 negative bit: set pin 1, clear low reference.
// [R10] Set A channel 0 negative bit behaves like set B.
// [R11] Channel 0 positive: pins 0-15, op amps 1-3, temperature diode, open.
// [R12] Channel 0 positive codes 10000-10111 and 11011-11101 are reserved.
// [R13] Shared op-amp/pin choices take the op amp when its mode bit is one.
// [R14] Unimplemented bits of channel 0 and buffer configuration registers read zero.
// [R15] Implemented bits are read/write and reset to zero.
// [R16] Set A channel 0 positive at bits 4-0 uses the set B encoding.
// [R17] Alternate bit set: set A then set B alternately; clear: always set A.
// [R18] Channel count: 00 channel 0, 01 channels 0-1, 1x channels 0-3.
// [R19] A reserved channel 0 positive code connects no input at all.
module adc_input_mux_dma_config (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [adc_mux_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [adc_mux_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Converter side
  input wire adc_mux_pkg::result_s conv_result,
  input wire logic sample_done,
  output adc_mux_pkg::result_s result_write,
  output logic [3:0] result_index,
  output logic dma_request,
  output logic [7:0] dma_words_per_input,
  // Input routing, element n is channel n
  output adc_mux_pkg::src_s [3:0] ch_pos_src,
  output adc_mux_pkg::src_s [3:0] ch_neg_src,
  output logic [3:0] channel_enable,
  output logic sample_set_b
);
  import adc_mux_pkg::*;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic result_dma_enable_q;
  logic [2:0] dma_words_per_input_q;
  logic [1:0] ch1to3_neg_sel_set_b_q, ch1to3_neg_sel_set_a_q;
  logic ch1to3_pos_sel_set_b_q, ch1to3_pos_sel_set_a_q;
  logic ch_zero_neg_sel_set_b_q, ch_zero_neg_sel_set_a_q;
  logic [4:0] ch_zero_pos_sel_set_b_q, ch_zero_pos_sel_set_a_q;
  logic twelve_bit_mode_select_q, alternate_sample_sets_q;
  logic [1:0] channel_count_select_q;
  logic [2:0] op_amp_mode_bit_q;
  logic set_b_q;
  logic [3:0] buf_ptr_q;
  logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic commit;
  logic [15:0] cur_val, new_val;

  // Byte-lane merge of a 16-bit register with a write.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
    merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  // An op amp shares its choice with a pin; the mode bit decides which drives it.
  function automatic src_s shared_src(input logic [1:0] amp, input logic [2:0] mode);
    src_s s;
    s.kind = mode[amp - 2'd1] ? SRC_OPAMP : SRC_PIN; // R13
    s.index = (amp == 2'd1) ? PIN_SHARED_OA1 : (amp == 2'd2) ? PIN_SHARED_OA2 : PIN_SHARED_OA3;
    if (s.kind == SRC_OPAMP) begin
      s.index = {2'b00, amp};
    end
    return s;
  endfunction

  function automatic src_s pin_src(input logic [3:0] n);
    return '{kind: SRC_PIN, index: n};
  endfunction

  // Channel 0 positive decode, shared by both sample sets.
  function automatic src_s ch0_pos(input logic [4:0] code, input logic [2:0] mode);
    src_s s;
    s = '{kind: SRC_NONE, index: 4'h0}; // R12 R19
    if (code[4] == 1'b0) begin
      s = pin_src(code[3:0]); // R11
    end else if (code >= CH0_OPAMP1 && code <= CH0_OPAMP3) begin
      s = shared_src(2'(code - CH0_OPAMP1 + 5'd1), mode); // R11
    end else if (code == CH0_TEMP) begin
      s = '{kind: SRC_TEMP, index: 4'h0};
    end else if (code == CH0_OPEN) begin
      s = '{kind: SRC_OPEN, index: 4'h0};
    end
    return s;
  endfunction

  // Register read view; absent fields are zero.
  function automatic logic [15:0] reg_view(input logic [ADDR_W-1:0] a, output logic hit);
    logic [15:0] v;
    v = 16'h0000;
    hit = 1'b1;
    if (a == OFF_BUF_DMA_CFG) begin
      v[POS_DMA_EN] = result_dma_enable_q; // R14
      v[POS_DMA_BL +: 3] = dma_words_per_input_q;
    end else if (a == OFF_CH123_SEL) begin
      if (!twelve_bit_mode_select_q) begin // R8
        v[POS_CH123_NEG_B +: 2] = ch1to3_neg_sel_set_b_q;
        v[POS_CH123_POS_B] = ch1to3_pos_sel_set_b_q;
        v[POS_CH123_NEG_A +: 2] = ch1to3_neg_sel_set_a_q;
        v[POS_CH123_POS_A] = ch1to3_pos_sel_set_a_q;
      end
    end else if (a == OFF_CH0_SEL) begin
      v[POS_CH0_NEG_B] = ch_zero_neg_sel_set_b_q; // R14
      v[POS_CH0_POS_B +: 5] = ch_zero_pos_sel_set_b_q;
      v[POS_CH0_NEG_A] = ch_zero_neg_sel_set_a_q;
      v[POS_CH0_POS_A +: 5] = ch_zero_pos_sel_set_a_q;
    end else if (a == OFF_MODE_CTRL) begin
      v[POS_TWELVE_BIT] = twelve_bit_mode_select_q;
      v[POS_ALT_SETS] = alternate_sample_sets_q;
      v[POS_CHAN_COUNT +: 2] = channel_count_select_q;
      v[POS_OPAMP_MODE +: 3] = op_amp_mode_bit_q;
    end else if (a == OFF_STATUS) begin
      v[POS_ST_SET_B] = set_b_q;
      v[POS_ST_BUF_PTR +: 4] = buf_ptr_q;
      v[POS_ST_CH_EN +: 4] = channel_enable;
    end else begin
      hit = 1'b0;
    end
    return v;
  endfunction

  // Write channel: address and data are taken independently, then committed together.
  assign awready = !aw_held_q && !bvalid_q;
  assign wready = !w_held_q && !bvalid_q;
  assign commit = aw_held_q && w_held_q && !bvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (awvalid && awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (commit) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (wvalid && wready) begin
      w_held_q <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (commit) begin
      w_held_q <= 1'b0;
    end
  end

  always_comb begin
    logic hit;
    hit = 1'b0;
    cur_val = reg_view(aw_addr_q, hit);
    new_val = merge16(cur_val, w_data_q, w_strb_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (commit) begin
      bvalid_q <= 1'b1;
      bresp_q <= (aw_addr_q == OFF_BUF_DMA_CFG || aw_addr_q == OFF_CH123_SEL ||
                  aw_addr_q == OFF_CH0_SEL || aw_addr_q == OFF_MODE_CTRL) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Writable register fields; all clear at reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {result_dma_enable_q, dma_words_per_input_q} <= 4'h0; // R15
      {ch_zero_neg_sel_set_b_q, ch_zero_pos_sel_set_b_q} <= 6'h00;
      {ch_zero_neg_sel_set_a_q, ch_zero_pos_sel_set_a_q} <= 6'h00;
      {twelve_bit_mode_select_q, alternate_sample_sets_q} <= 2'h0;
      channel_count_select_q <= 2'h0;
      op_amp_mode_bit_q <= 3'h0;
    end else if (commit) begin
      if (aw_addr_q == OFF_BUF_DMA_CFG) begin
        result_dma_enable_q <= new_val[POS_DMA_EN];
        dma_words_per_input_q <= new_val[POS_DMA_BL +: 3];
      end else if (aw_addr_q == OFF_CH0_SEL) begin
        ch_zero_neg_sel_set_b_q <= new_val[POS_CH0_NEG_B];
        ch_zero_pos_sel_set_b_q <= new_val[POS_CH0_POS_B +: 5];
        ch_zero_neg_sel_set_a_q <= new_val[POS_CH0_NEG_A];
        ch_zero_pos_sel_set_a_q <= new_val[POS_CH0_POS_A +: 5];
      end else if (aw_addr_q == OFF_MODE_CTRL) begin
        twelve_bit_mode_select_q <= new_val[POS_TWELVE_BIT];
        alternate_sample_sets_q <= new_val[POS_ALT_SETS];
        channel_count_select_q <= new_val[POS_CHAN_COUNT +: 2];
        op_amp_mode_bit_q <= new_val[POS_OPAMP_MODE +: 3];
      end
    end
  end

  // Channel 1-3 fields do not exist in 12-bit mode, so writes then are dropped.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {ch1to3_neg_sel_set_b_q, ch1to3_pos_sel_set_b_q} <= 3'h0; // R15
      {ch1to3_neg_sel_set_a_q, ch1to3_pos_sel_set_a_q} <= 3'h0;
    end else if (commit && aw_addr_q == OFF_CH123_SEL && !twelve_bit_mode_select_q) begin
      ch1to3_neg_sel_set_b_q <= new_val[POS_CH123_NEG_B +: 2];
      ch1to3_pos_sel_set_b_q <= new_val[POS_CH123_POS_B];
      ch1to3_neg_sel_set_a_q <= new_val[POS_CH123_NEG_A +: 2];
      ch1to3_pos_sel_set_a_q <= new_val[POS_CH123_POS_A];
    end
  end

  // Read channel: one outstanding read, answered the cycle after it is taken.
  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always_ff @(posedge aclk) begin
    logic hit;
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= {16'h0000, reg_view(araddr, hit)};
      rresp_q <= hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  a_chs123_read_zero: assert property (arvalid && arready && araddr == OFF_CH123_SEL &&
    twelve_bit_mode_select_q |=> rvalid && rdata == 32'h0) // R8
    else $error("channel 1-3 select read nonzero in 12-bit mode");
  a_unimpl_read_zero: assert property (arvalid && arready && (araddr == OFF_CH0_SEL ||
    araddr == OFF_BUF_DMA_CFG) |=> (rdata & 32'hffff6060) == 32'h0 &&
    (($past(araddr) != OFF_BUF_DMA_CFG) || (rdata & 32'hfffffef8) == 32'h0)) // R14
    else $error("unimplemented bits read nonzero");

  // Sample-set sequencing: alternate sets start on A and flip after each completed sequence.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      set_b_q <= 1'b0;
    end else if (!alternate_sample_sets_q) begin
      set_b_q <= 1'b0; // R17
    end else if (sample_done) begin
      set_b_q <= !set_b_q; // R17
    end
  end

  sequence s_alt_done;
    alternate_sample_sets_q && sample_done;
  endsequence
  sequence s_set_flips;
    ##1 (set_b_q != $past(set_b_q));
  endsequence
  a_alt_sets_flip: assert property (s_alt_done |-> s_set_flips) // R17
    else $error("sample set did not alternate");
  a_single_set_a: assert property (!alternate_sample_sets_q |=> !set_b_q) // R17
    else $error("set B used while alternation is off");

  // Result steering: DMA keeps every result in the first slot and asks for a transfer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_ptr_q <= RST_BUF_PTR;
    end else if (result_dma_enable_q) begin
      buf_ptr_q <= RST_BUF_PTR; // R1
    end else if (conv_result.valid) begin
      buf_ptr_q <= buf_ptr_q + 4'h1; // R2
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_write <= '0;
      result_index <= 4'h0;
      dma_request <= 1'b0;
      dma_words_per_input <= 8'h01;
    end else begin
      result_write <= conv_result;
      result_index <= result_dma_enable_q ? RST_BUF_PTR : buf_ptr_q; // R1 R2
      dma_request <= conv_result.valid && result_dma_enable_q; // R1 R2
      dma_words_per_input <= 8'h01 << dma_words_per_input_q; // R3
    end
  end

  a_dma_first_slot: assert property (conv_result.valid && result_dma_enable_q |=>
    result_write.valid && result_index == 4'h0 && dma_request) // R1
    else $error("DMA result not in first slot");
  a_buffer_no_dma: assert property (conv_result.valid && !result_dma_enable_q |=>
    !dma_request && result_index == $past(buf_ptr_q) && buf_ptr_q == result_index + 4'h1) // R2
    else $error("buffered result misplaced or DMA requested");
  a_words_per_input: assert property ($changed(dma_words_per_input_q) |=>
    dma_words_per_input == (8'h01 << $past(dma_words_per_input_q))) // R3
    else $error("words per input mismatch");

  // Input routing for the active sample set.
  src_s [3:0] pos_d, neg_d;
  logic [3:0] en_d;

  always_comb begin
    logic [1:0] neg123;
    logic pos123, neg0;
    logic [4:0] pos0;
    neg123 = set_b_q ? ch1to3_neg_sel_set_b_q : ch1to3_neg_sel_set_a_q; // R5
    pos123 = set_b_q ? ch1to3_pos_sel_set_b_q : ch1to3_pos_sel_set_a_q; // R7
    neg0 = set_b_q ? ch_zero_neg_sel_set_b_q : ch_zero_neg_sel_set_a_q; // R10
    pos0 = set_b_q ? ch_zero_pos_sel_set_b_q : ch_zero_pos_sel_set_a_q; // R16
    pos_d[0] = ch0_pos(pos0, op_amp_mode_bit_q); // R11
    neg_d[0] = neg0 ? pin_src(PIN_CH0_NEG) : '{kind: SRC_LOW_REF, index: 4'h0}; // R9
    if (pos123) begin
      pos_d[1] = shared_src(2'd1, op_amp_mode_bit_q); // R6
      pos_d[2] = shared_src(2'd2, op_amp_mode_bit_q);
      pos_d[3] = shared_src(2'd3, op_amp_mode_bit_q);
    end else begin
      pos_d[1] = shared_src(2'd2, op_amp_mode_bit_q); // R6
      pos_d[2] = pin_src(4'h1);
      pos_d[3] = pin_src(4'h2);
    end
    for (int i = 1; i < 4; i++) begin
      if (neg123 == 2'b11) begin
        neg_d[i] = pin_src(4'(PIN_LOW_NEG + 4'(i - 1))); // R4
      end else if (neg123 == 2'b10) begin
        neg_d[i] = pin_src(4'(PIN_HIGH_NEG_CH2 + 4'(i - 2))); // R4
      end else begin
        neg_d[i] = '{kind: SRC_LOW_REF, index: 4'h0}; // R4
      end
    end
    if (neg123 == 2'b10) begin
      neg_d[1] = shared_src(2'd3, op_amp_mode_bit_q); // R4 R13
    end
    // 12-bit mode has only channel 0 and no channel count choice.
    if (twelve_bit_mode_select_q) begin
      en_d = 4'b0001; // R8
    end else if (channel_count_select_q[1]) begin
      en_d = 4'b1111; // R18
    end else if (channel_count_select_q[0]) begin
      en_d = 4'b0011; // R18
    end else begin
      en_d = 4'b0001; // R18
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch_pos_src <= '0;
      ch_neg_src <= '0;
      channel_enable <= 4'h0;
      sample_set_b <= 1'b0;
    end else begin
      ch_pos_src <= pos_d;
      ch_neg_src <= neg_d;
      channel_enable <= en_d;
      sample_set_b <= set_b_q;
    end
  end

  a_neg_pins_9_11: assert property (!set_b_q && ch1to3_neg_sel_set_a_q == 2'b11 |=>
    ch_neg_src[1].index == 4'h9 && ch_neg_src[3].index == 4'hb &&
    ch_neg_src[3].kind == SRC_PIN) // R4
    else $error("negative pins 9-11 not routed");
  a_pos_opamp_route: assert property (pos_d[1].kind == SRC_OPAMP |->
    ##1 ch_pos_src[1].kind == SRC_OPAMP && $past(op_amp_mode_bit_q[pos_d[1].index[1:0] - 2'd1])) // R13
    else $error("op amp routed while its mode bit is zero");
  a_ch0_neg_pin1: assert property (set_b_q && ch_zero_neg_sel_set_b_q |=>
    ch_neg_src[0].kind == SRC_PIN && ch_neg_src[0].index == 4'h1) // R9
    else $error("channel 0 negative not pin 1");
  a_ch0_reserved: assert property ((pos_d[0].kind == SRC_NONE) |->
    (set_b_q ? ch_zero_pos_sel_set_b_q : ch_zero_pos_sel_set_a_q) inside
    {[5'h10:5'h17], [5'h1b:5'h1d]}) // R19
    else $error("no-input routing for a defined code");
  a_chan_count: assert property (!twelve_bit_mode_select_q && channel_count_select_q == 2'b01
    |=> channel_enable == 4'b0011) // R18
    else $error("channel count 01 not channels 0-1");

  a_reset_clears: assert property (disable iff (1'b0) !aresetn |=> !result_dma_enable_q &&
    dma_words_per_input_q == 3'h0 && ch_zero_pos_sel_set_a_q == 5'h00 && !op_amp_mode_bit_q[0]) // R15
    else $error("register not cleared by reset");
endmodule

`default_nettype wire

//--- testbench/tb_top.sv
// Purpose: Self-checking bench for the converter buffer and input-routing registers.
// Assumes: AXI4-Lite master driven here; results checked at the falling edge, bus responses at the rising edge.
// Notes: Protection and strobes are tied; every register write is a full word.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import adc_mux_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sample_done;
  logic awready, wready, bvalid, arready, rvalid, dma_request, sample_set_b;
  logic [7:0] awaddr, araddr, dma_words_per_input;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, result_index, channel_enable;
  logic [1:0] bresp, rresp;
  result_s conv_result, result_write;
  src_s [3:0] ch_pos_src, ch_neg_src;
  int n_errors = 0, checked = 0;
  adc_input_mux_dma_config dut_u (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .arprot, .rvalid, .rready, .rdata, .rresp, .conv_result, .sample_done,
    .result_write, .result_index, .dma_request, .dma_words_per_input, .ch_pos_src,
    .ch_neg_src, .channel_enable, .sample_set_b);
  initial begin
    aclk = 0;
    forever #25 aclk = ~aclk;
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [31:0] sx(input src_kind_e k, input logic [3:0] i);
    return {25'h0, k, i};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit pa, pw;
    pa = 1;
    pw = 1;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && awready === 1'b1) begin
        awvalid <= 1'b0;
        pa = 0;
      end
      if (pw && wready === 1'b1) begin
        wvalid <= 1'b0;
        pw = 0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
    repeat (2) @(negedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", rdata, e);
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask
  task automatic res(input logic [11:0] d, input logic [3:0] ix, input logic dq);
    @(posedge aclk);
    conv_result <= '{1'b1, d};
    @(posedge aclk);
    conv_result <= '{1'b0, 12'h0};
    @(negedge aclk);
    chk("result", {19'h0, result_write}, {19'h0, 1'b1, d});
    chk("index", {28'h0, result_index}, {28'h0, ix});
    chk("dma_request", {31'h0, dma_request}, {31'h0, dq});
  endtask
  task automatic pulse_done();
    @(posedge aclk);
    sample_done <= 1'b1;
    @(posedge aclk);
    sample_done <= 1'b0;
    repeat (2) @(negedge aclk);
  endtask
  task automatic t_reset();
    rd(OFF_BUF_DMA_CFG, 32'h0, RESP_OKAY);
    rd(OFF_CH123_SEL, 32'h0, RESP_OKAY);
    rd(OFF_CH0_SEL, 32'h0, RESP_OKAY);
    rd(8'h20, 32'h0, RESP_SLVERR);
    chk("words", {24'h0, dma_words_per_input}, 32'h1);
    chk("enables", {28'h0, channel_enable}, 32'h1);
    chk("neg0", {25'h0, ch_neg_src[0]}, sx(SRC_LOW_REF, 4'h0));
  endtask
  task automatic t_regs();
    wr(OFF_BUF_DMA_CFG, 32'hffffffff, RESP_OKAY);
    rd(OFF_BUF_DMA_CFG, 32'h107, RESP_OKAY);
    chk("words", {24'h0, dma_words_per_input}, 32'h80);
    wr(OFF_BUF_DMA_CFG, 32'h3, RESP_OKAY);
    chk("words", {24'h0, dma_words_per_input}, 32'h8);
    wr(OFF_CH0_SEL, 32'hffffffff, RESP_OKAY);
    rd(OFF_CH0_SEL, 32'h9f9f, RESP_OKAY);
    wr(OFF_CH123_SEL, 32'hffffffff, RESP_OKAY);
    rd(OFF_CH123_SEL, 32'h707, RESP_OKAY);
    wr(OFF_STATUS, 32'hffffffff, RESP_SLVERR);
  endtask
  task automatic t_result();
    wr(OFF_BUF_DMA_CFG, 32'h100, RESP_OKAY);
    res(12'h5a5, 4'h0, 1'b1);
    res(12'ha5a, 4'h0, 1'b1);
    wr(OFF_BUF_DMA_CFG, 32'h0, RESP_OKAY);
    res(12'h123, 4'h0, 1'b0);
    res(12'h321, 4'h1, 1'b0);
  endtask
  task automatic t_ch0();
    logic [4:0] cd [11] = '{5'h00, 5'h0f, 5'h18, 5'h1a, 5'h1e, 5'h1f, 5'h10, 5'h17,
                            5'h1b, 5'h1d, 5'h19};
    src_kind_e kd [11] = '{SRC_PIN, SRC_PIN, SRC_PIN, SRC_PIN, SRC_TEMP, SRC_OPEN,
                           SRC_NONE, SRC_NONE, SRC_NONE, SRC_NONE, SRC_OPAMP};
    logic [3:0] ix [11] = '{4'h0, 4'hf, 4'h3, 4'h6, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2};
    for (int n = 0; n < 11; n++) begin
      if (n == 10) wr(OFF_MODE_CTRL, 32'h20, RESP_OKAY);
      wr(OFF_CH0_SEL, {24'h0, 3'h4, cd[n]}, RESP_OKAY);
      chk("pos0 kind", {29'h0, ch_pos_src[0].kind}, {29'h0, kd[n]});
      if (kd[n] == SRC_PIN || kd[n] == SRC_OPAMP) begin
        chk("pos0 index", {28'h0, ch_pos_src[0].index}, {28'h0, ix[n]});
      end
      chk("neg0", {25'h0, ch_neg_src[0]}, sx(SRC_PIN, 4'h1));
    end
  endtask
  task automatic t_ch123();
    wr(OFF_MODE_CTRL, 32'h0, RESP_OKAY);
    wr(OFF_CH123_SEL, 32'h6, RESP_OKAY);
    for (int n = 1; n < 4; n++) begin
      chk("neg", {25'h0, ch_neg_src[n]}, sx(SRC_PIN, 4'(n + 8)));
      chk("pos", {25'h0, ch_pos_src[n]}, sx(SRC_PIN, 4'(n - 1)));
    end
    wr(OFF_MODE_CTRL, 32'h1, RESP_OKAY);
    rd(OFF_CH123_SEL, 32'h0, RESP_OKAY);
    wr(OFF_MODE_CTRL, 32'h8, RESP_OKAY);
    chk("enables", {28'h0, channel_enable}, 32'hf);
    wr(OFF_MODE_CTRL, 32'h4, RESP_OKAY);
    chk("enables", {28'h0, channel_enable}, 32'h3);
  endtask
  task automatic t_alt();
    wr(OFF_MODE_CTRL, 32'h72, RESP_OKAY);
    wr(OFF_CH123_SEL, 32'h700, RESP_OKAY);
    wr(OFF_CH0_SEL, 32'h9e00, RESP_OKAY);
    pulse_done();
    chk("set b", {31'h0, sample_set_b}, 32'h1);
    chk("pos1", {25'h0, ch_pos_src[1]}, sx(SRC_OPAMP, 4'h1));
    chk("pos3", {25'h0, ch_pos_src[3]}, sx(SRC_OPAMP, 4'h3));
    chk("neg2", {25'h0, ch_neg_src[2]}, sx(SRC_PIN, 4'ha));
    chk("pos0 kind", {29'h0, ch_pos_src[0].kind}, {29'h0, SRC_TEMP});
    chk("neg0", {25'h0, ch_neg_src[0]}, sx(SRC_PIN, 4'h1));
    pulse_done();
    chk("set b", {31'h0, sample_set_b}, 32'h0);
    chk("neg0", {25'h0, ch_neg_src[0]}, sx(SRC_LOW_REF, 4'h0));
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, sample_done} = '0;
    {awaddr, araddr, wdata} = '0;
    awprot = 3'h0;
    arprot = 3'h0;
    wstrb = 4'hf;
    conv_result = '{1'b0, 12'h0};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    t_reset();
    t_regs();
    t_result();
    t_ch0();
    t_ch123();
    t_alt();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
